/* File: design/csel_pkg.sv */
// shared constants and types for the clock strap select block
package csel_pkg;

  // register byte offsets
  localparam logic [7:0] CSEL_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CSEL_OFF_STRAP  = 8'h04;
  localparam logic [7:0] CSEL_OFF_FREQ   = 8'h08;
  localparam logic [7:0] CSEL_OFF_STATUS = 8'h0C;

  // control register fields
  localparam int CSEL_CTRL_REFA_DBL = 0;
  localparam int CSEL_CTRL_SIO_48   = 1;
  localparam logic [1:0] CSEL_CTRL_RESET = 2'h0;

  // strap register field positions
  localparam int CSEL_STRAP_FS_LSB  = 0;
  localparam int CSEL_STRAP_FAMILY  = 4;
  localparam int CSEL_STRAP_MULT    = 5;
  localparam int CSEL_STRAP_MODE    = 6;
  localparam int CSEL_STRAP_VALID   = 7;

  // status register field positions
  localparam int CSEL_STAT_OUT_EN   = 0;
  localparam int CSEL_STAT_PG_DONE  = 1;
  localparam int CSEL_STAT_PROC_RUN = 2;

  // rates in units of 10 kHz; the frequency register packs proc[31:16] and bus[15:0]
  localparam int CSEL_FREQ_W = 16;

  // timing: strap sampling settle time after reset release
  localparam int CSEL_CLK_MHZ       = 50;
  localparam int CSEL_SETTLE_NS     = 100;
  localparam int CSEL_SETTLE_CYC    = (CSEL_SETTLE_NS * CSEL_CLK_MHZ + 999) / 1000;

  // output current multipliers
  localparam logic [2:0] CSEL_MULT_LOW  = 3'h4;
  localparam logic [2:0] CSEL_MULT_HIGH = 3'h6;

  typedef enum logic [1:0] {
    CSEL_ST_SETTLE,
    CSEL_ST_WAIT_PG,
    CSEL_ST_RUN
  } csel_state_t;

endpackage : csel_pkg

/* File: design/csel_freq_rom.sv */
// frequency select code to processor, graphics and bus rates (10 kHz units)
module csel_freq_rom
  import csel_pkg::*;
(
  // code in
  input  wire logic [3:0]             code,
  // rates out
  output logic      [CSEL_FREQ_W-1:0] proc_rate,
  output logic      [CSEL_FREQ_W-1:0] gfx_rate,
  output logic      [CSEL_FREQ_W-1:0] bus_rate
);

  always_comb begin
    case (code)
      4'h0:    begin proc_rate = 16'h1A18; gfx_rate = 16'h1A18; bus_rate = 16'h0D0C; end
      4'h1:    begin proc_rate = 16'h2724; gfx_rate = 16'h1A18; bus_rate = 16'h0D0C; end
      4'h2:    begin proc_rate = 16'h2EE0; gfx_rate = 16'h1770; bus_rate = 16'h0BB8; end
      4'h3:    begin proc_rate = 16'h3415; gfx_rate = 16'h1A0B; bus_rate = 16'h0D05; end
      4'h4:    begin proc_rate = 16'h1C20; gfx_rate = 16'h1C20; bus_rate = 16'h0E10; end
      4'h5:    begin proc_rate = 16'h2904; gfx_rate = 16'h1B58; bus_rate = 16'h0DAC; end
      4'h6:    begin proc_rate = 16'h3E80; gfx_rate = 16'h1900; bus_rate = 16'h0C80; end
      4'h7:    begin proc_rate = 16'h36B0; gfx_rate = 16'h1B58; bus_rate = 16'h0DAC; end
      4'h8:    begin proc_rate = 16'h1E14; gfx_rate = 16'h1E14; bus_rate = 16'h0F0A; end
      4'h9:    begin proc_rate = 16'h2AF8; gfx_rate = 16'h1CA5; bus_rate = 16'h0E53; end
      4'hA:    begin proc_rate = 16'h4650; gfx_rate = 16'h1770; bus_rate = 16'h0BB8; end
      4'hB:    begin proc_rate = 16'h3A98; gfx_rate = 16'h1770; bus_rate = 16'h0BB8; end
      4'hC:    begin proc_rate = 16'h2328; gfx_rate = 16'h1770; bus_rate = 16'h0BB8; end
      4'hD:    begin proc_rate = 16'h2710; gfx_rate = 16'h1A0B; bus_rate = 16'h0D05; end
      4'hE:    begin proc_rate = 16'h4E20; gfx_rate = 16'h1A0B; bus_rate = 16'h0D05; end
      default: begin proc_rate = 16'h3415; gfx_rate = 16'h1A0B; bus_rate = 16'h0D05; end
    endcase
  end

endmodule : csel_freq_rom

/* File: design/csel_clock_strap_select.sv */
// strap capture, pin function switching and clock gating for the clock generator
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
module csel_clock_strap_select
  import csel_pkg::*;
#(
  parameter int SETTLE_CYC = CSEL_SETTLE_CYC,
  parameter int MEM_PAIRS  = 6
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // internal clock sources
  input  wire logic                 crystal_input,
  input  wire logic                 proc_clk_src,
  input  wire logic                 gfx_clk_src,
  input  wire logic                 bus_clk_src,
  input  wire logic                 usb_clk_src,
  input  wire logic                 sio24_clk_src,
  input  wire logic                 mem_buffer_in,
  // dual-purpose strap pins: input, output, output enable
  input  wire logic                 select_bit_zero,
  output logic                      reference_out_a,
  output logic                      reference_out_a_oe,
  output logic                      reference_out_a_dbl,
  input  wire logic                 select_bit_one,
  output logic                      bus_clock_free,
  output logic                      bus_clock_free_oe,
  input  wire logic                 select_bit_two,
  output logic                      superio_clock_out,
  output logic                      superio_clock_out_oe,
  input  wire logic                 select_bit_three,
  output logic                      usb_clock_out,
  output logic                      usb_clock_out_oe,
  input  wire logic                 processor_family_strap,
  output logic                      graphics_clock_one,
  output logic                      graphics_clock_one_oe,
  input  wire logic                 current_multiplier_strap,
  output logic                      bus_clock_two,
  output logic                      bus_clock_two_oe,
  input  wire logic                 mode_strap,
  output logic                      graphics_clock_zero,
  output logic                      graphics_clock_zero_oe,
  input  wire logic                 power_good_gate_n,
  output logic                      reference_out_b,
  output logic                      reference_out_b_oe,
  // power management inputs
  input  wire logic                 proc_clock_stop_n,
  // processor pair: true and complement, each with enable
  output logic                      proc_clock_true,
  output logic                      proc_clock_true_oe,
  output logic                      proc_clock_comp,
  output logic                      proc_clock_comp_oe,
  // plain clock outputs
  output logic                      bus_clock_one,
  output logic [MEM_PAIRS-1:0]      memory_clock_true,
  output logic [MEM_PAIRS-1:0]      memory_clock_comp,
  // latched configuration views
  output logic [2:0]                drive_current_mult,
  output logic [CSEL_FREQ_W-1:0]    proc_rate,
  output logic [CSEL_FREQ_W-1:0]    gfx_rate,
  output logic [CSEL_FREQ_W-1:0]    bus_rate
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    csel_state_t st;
    logic [15:0] settle_cnt;
    logic [3:0]  fs;
    logic        family;
    logic        mult;
    logic        mode;
    logic        valid;
    logic        fs_done;
    logic        out_en;
    logic        pg_done;
    logic [1:0]  ctrl;
    logic        proc_run;
    logic        proc_prev;
    logic        bus_pend;
    logic        bus_wr;
    logic [7:0]  bus_addr;
    logic [31:0] rdata;
  } csel_regs_t;

  csel_regs_t s_reg;
  csel_regs_t s_next;

  logic [CSEL_FREQ_W-1:0] rom_proc;
  logic [CSEL_FREQ_W-1:0] rom_gfx;
  logic [CSEL_FREQ_W-1:0] rom_bus;

  csel_freq_rom u_rom (
    .code      (s_reg.fs),
    .proc_rate (rom_proc),
    .gfx_rate  (rom_gfx),
    .bus_rate  (rom_bus)
  );

  function automatic logic [31:0] csel_read(input logic [7:0] a, input csel_regs_t s);
    case (a)
      CSEL_OFF_CTRL:   csel_read = {30'h0, s.ctrl};
      CSEL_OFF_STRAP:  csel_read = {24'h0, s.valid, s.mode, s.mult, s.family, s.fs};
      CSEL_OFF_FREQ:   csel_read = {rom_proc, rom_bus};
      CSEL_OFF_STATUS: csel_read = {29'h0, s.proc_run, s.pg_done, s.out_en};
      default:         csel_read = 32'h0000_0000;
    endcase
  endfunction : csel_read

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next = s_reg;
    // bus data phase: writes land here, reads were captured at address phase
    if (s_reg.bus_pend && s_reg.bus_wr && s_reg.bus_addr == CSEL_OFF_CTRL) begin
      s_next.ctrl = hwdata[1:0];
    end
    s_next.bus_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_next.bus_pend = 1'b1;
      s_next.bus_wr   = hwrite;
      s_next.bus_addr = haddr[7:0];
      if (!hwrite) begin
        s_next.rdata = csel_read(haddr[7:0], s_reg);
      end
    end

    case (s_reg.st)
      CSEL_ST_SETTLE: begin
        // pins are inputs until supply settles; then straps are taken once
        if (s_reg.settle_cnt >= 16'(SETTLE_CYC - 1)) begin
          s_next.fs[0]  = select_bit_zero;
          s_next.fs[1]  = select_bit_one;
          s_next.fs[2]  = select_bit_two;
          s_next.fs[3]  = select_bit_three;
          s_next.family = processor_family_strap;
          s_next.mult   = current_multiplier_strap;
          s_next.mode   = mode_strap;
          s_next.valid  = 1'b1;
          if (processor_family_strap) begin
            s_next.st = CSEL_ST_WAIT_PG;
          end else begin
            s_next.fs_done = 1'b1;
            s_next.out_en  = 1'b1;
            s_next.st      = CSEL_ST_RUN;
          end
        end else begin
          s_next.settle_cnt = s_reg.settle_cnt + 16'h0001;
        end
      end
      CSEL_ST_WAIT_PG: begin
        // code and multiplier re-taken while power-good is high; pins still inputs except the two graphics clock pins, driven low
        if (!power_good_gate_n) begin
          s_next.fs_done = 1'b1;
          s_next.out_en  = 1'b1;
          s_next.pg_done = 1'b1;
          s_next.st      = CSEL_ST_RUN;
        end else begin
          s_next.fs   = {select_bit_three, select_bit_two, select_bit_one, select_bit_zero};
          s_next.mult = current_multiplier_strap;
        end
      end
      CSEL_ST_RUN: begin
        // straps frozen, power-good no longer looked at
        s_next.st = CSEL_ST_RUN;
      end
      default: s_next.st = CSEL_ST_SETTLE;
    endcase

    // processor clock stop takes effect at the falling edge of the source
    s_next.proc_prev = proc_clk_src;
    if (s_reg.proc_prev && !proc_clk_src) begin
      s_next.proc_run = !(s_reg.mode == 1'b0 && !proc_clock_stop_n);
    end else if (!s_reg.proc_run && !proc_clk_src) begin
      s_next.proc_run = !(s_reg.mode == 1'b0 && !proc_clock_stop_n);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: CSEL_ST_SETTLE, ctrl: CSEL_CTRL_RESET, proc_run: 1'b1, default: '0};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic en;
  logic proc_gate;
  assign en        = s_reg.out_en;
  // run only changes while the source is seen low, so a stop or restart never chops a high phase of proc_clock_true;
  // a source that toggles every core cycle is too fast for this and may be cut short
  assign proc_gate = en && s_reg.proc_run;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;

  assign reference_out_a        = en & crystal_input;
  assign reference_out_a_oe     = s_reg.fs_done;
  assign reference_out_a_dbl    = s_reg.ctrl[CSEL_CTRL_REFA_DBL];
  assign bus_clock_free         = en & bus_clk_src;
  assign bus_clock_free_oe      = s_reg.fs_done;
  assign superio_clock_out      = en & (s_reg.ctrl[CSEL_CTRL_SIO_48] ?
                                        usb_clk_src : sio24_clk_src);
  assign superio_clock_out_oe   = s_reg.fs_done;
  assign usb_clock_out          = en & usb_clk_src;
  assign usb_clock_out_oe       = s_reg.fs_done;
  assign graphics_clock_one     = en & gfx_clk_src;
  assign graphics_clock_one_oe  = s_reg.valid;
  assign bus_clock_two          = en & bus_clk_src;
  assign bus_clock_two_oe       = s_reg.fs_done;
  assign graphics_clock_zero    = en & gfx_clk_src;
  assign graphics_clock_zero_oe = s_reg.valid;
  assign reference_out_b        = en & crystal_input;
  assign reference_out_b_oe     = s_reg.valid & ~s_reg.family;
  assign bus_clock_one          = en & bus_clk_src;

  // open-drain form drives only low, release stands for high
  always_comb begin
    if (s_reg.family) begin
      proc_clock_true    = proc_gate & proc_clk_src;
      proc_clock_comp    = proc_gate & ~proc_clk_src;
      proc_clock_true_oe = en;
      proc_clock_comp_oe = en;
    end else begin
      proc_clock_true    = 1'b0;
      proc_clock_comp    = 1'b0;
      proc_clock_true_oe = en & ~(proc_gate & proc_clk_src);
      proc_clock_comp_oe = en & ~(proc_gate & ~proc_clk_src);
    end
  end

  assign memory_clock_true  = {MEM_PAIRS{mem_buffer_in}};
  assign memory_clock_comp  = {MEM_PAIRS{~mem_buffer_in}};
  assign drive_current_mult = s_reg.mult ? CSEL_MULT_HIGH : CSEL_MULT_LOW;
  assign proc_rate          = rom_proc;
  assign gfx_rate           = rom_gfx;
  assign bus_rate           = rom_bus;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_straps_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_reg.st == CSEL_ST_RUN && clk_en) |=> $stable(s_reg.fs) && $stable(s_reg.family))
    else $error("strap value moved after latch");

  a_pg_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_reg.pg_done |=> s_reg.pg_done && s_reg.out_en)
    else $error("power-good gating reopened");

  a_pg_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_reg.st == CSEL_ST_WAIT_PG && !power_good_gate_n && clk_en) |=> s_reg.out_en)
    else $error("outputs not enabled after power-good low");

  a_second_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_reg.valid && !s_reg.family) |-> (reference_out_b_oe && !s_reg.pg_done))
    else $error("second mode still gated by power-good");

  a_mem_inverse: assert property (@(posedge core_clk) disable iff (!rst_n)
    memory_clock_comp == ~memory_clock_true)
    else $error("memory complement not inverse");

  a_current_mult: assert property (@(posedge core_clk) disable iff (!rst_n)
    drive_current_mult == (s_reg.mult ? 3'h6 : 3'h4))
    else $error("wrong current multiplier");

  a_opendrain: assert property (@(posedge core_clk) disable iff (!rst_n)
    !s_reg.family |-> (!proc_clock_true && !proc_clock_comp))
    else $error("open-drain pair drove high");

  a_stop_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_reg.mode && s_reg.proc_run && clk_en) |=> s_reg.proc_run)
    else $error("stop acted with mode strap high");

  a_refa_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> !reference_out_a_dbl)
    else $error("reference strength not single after reset");

endmodule : csel_clock_strap_select

/* File: tb/csel_board_model.sv */
// board side of the shared strap pins: strap resistors, power-good source, pair termination
module csel_board_model (
  // strap resistor levels, bit 7 is the power-good level
  input  wire logic [7:0] strap_lvl,
  // device drivers on the shared pins
  input  wire logic [7:0] drv_val,
  input  wire logic [7:0] drv_oe,
  // processor pair drivers, true in bit 1
  input  wire logic [1:0] proc_val,
  input  wire logic [1:0] proc_oe,
  // resolved wire levels
  output logic      [7:0] pin_lvl,
  output logic      [1:0] proc_lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  // a strap resistor only sets the level while the device leaves the pin undriven
  assign pin_lvl  = (drv_oe & drv_val) | (~drv_oe & strap_lvl);
  // pair legs are terminated high, so a released open-drain leg reads as 1
  assign proc_lvl = (proc_oe & proc_val) | ~proc_oe;
endmodule : csel_board_model

/* File: tb/tb_clock_strap_select.sv */
// self-checking bench for the clock strap select block
module tb_clock_strap_select
  import csel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SETTLE = 2;
  // {proc, graphics, bus} rates per select code, 10 kHz units
  localparam logic [47:0] RATE_TBL [16] = '{
    48'h1A18_1A18_0D0C, 48'h2724_1A18_0D0C, 48'h2EE0_1770_0BB8, 48'h3415_1A0B_0D05,
    48'h1C20_1C20_0E10, 48'h2904_1B58_0DAC, 48'h3E80_1900_0C80, 48'h36B0_1B58_0DAC,
    48'h1E14_1E14_0F0A, 48'h2AF8_1CA5_0E53, 48'h4650_1770_0BB8, 48'h3A98_1770_0BB8,
    48'h2328_1770_0BB8, 48'h2710_1A0B_0D05, 48'h4E20_1A0B_0D05, 48'h3415_1A0B_0D05
  };

  logic        core_clk, rst_n, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, proc_lvl;
  logic [2:0]  hsize, drive_current_mult;
  logic [5:0]  src_cnt, memory_clock_true, memory_clock_comp;
  logic        crystal_input, proc_clk_src, gfx_clk_src, bus_clk_src, usb_clk_src;
  logic        sio24_clk_src, mem_buffer_in, proc_clock_stop_n, sio48, fam, mlt, mde;
  logic        select_bit_zero, select_bit_one, select_bit_two, select_bit_three;
  logic        processor_family_strap, current_multiplier_strap, mode_strap, power_good_gate_n;
  logic        reference_out_a, reference_out_a_oe, reference_out_a_dbl, bus_clock_one;
  logic        bus_clock_free, bus_clock_free_oe, superio_clock_out, superio_clock_out_oe;
  logic        usb_clock_out, usb_clock_out_oe, graphics_clock_one, graphics_clock_one_oe;
  logic        bus_clock_two, bus_clock_two_oe, graphics_clock_zero, graphics_clock_zero_oe;
  logic        reference_out_b, reference_out_b_oe;
  logic        proc_clock_true, proc_clock_true_oe, proc_clock_comp, proc_clock_comp_oe;
  logic [15:0] proc_rate, gfx_rate, bus_rate;
  logic [7:0]  strap, pin_lvl, drv_val, drv_oe;
  logic [12:0] out_vec, src_vec;
  int          fail_count, compares;

  ////////////////////////////////////////////////////////////////////////////////
  // sources run slower than one toggle a cycle so a stuck output cannot hide in the lag
  assign {usb_clk_src, bus_clk_src, gfx_clk_src, proc_clk_src, crystal_input} = src_cnt[5:1];
  assign sio24_clk_src = src_cnt[1] ^ src_cnt[3];
  assign mem_buffer_in = src_cnt[2] ^ src_cnt[4];
  assign hready        = hreadyout;
  assign drv_val = {reference_out_b, graphics_clock_zero, bus_clock_two, graphics_clock_one,
                    usb_clock_out, superio_clock_out, bus_clock_free, reference_out_a};
  assign drv_oe  = {reference_out_b_oe, graphics_clock_zero_oe, bus_clock_two_oe,
                    graphics_clock_one_oe, usb_clock_out_oe, superio_clock_out_oe,
                    bus_clock_free_oe, reference_out_a_oe};
  assign {power_good_gate_n, mode_strap, current_multiplier_strap, processor_family_strap,
          select_bit_three, select_bit_two, select_bit_one, select_bit_zero} = pin_lvl;
  assign out_vec = {reference_out_b, proc_lvl[1], ~proc_lvl[0], memory_clock_true[0],
                    ~memory_clock_comp[5], bus_clock_one, graphics_clock_zero, bus_clock_two,
                    graphics_clock_one, usb_clock_out, superio_clock_out, bus_clock_free,
                    reference_out_a};
  assign src_vec = {crystal_input, proc_clk_src, proc_clk_src, mem_buffer_in, mem_buffer_in,
                    bus_clk_src, gfx_clk_src, bus_clk_src, gfx_clk_src, usb_clk_src,
                    sio48 ? usb_clk_src : sio24_clk_src, bus_clk_src, crystal_input};

  csel_board_model board (.strap_lvl(strap), .drv_val, .drv_oe,
    .proc_val({proc_clock_true, proc_clock_comp}),
    .proc_oe({proc_clock_true_oe, proc_clock_comp_oe}), .pin_lvl, .proc_lvl);

  csel_clock_strap_select #(.SETTLE_CYC(SETTLE), .MEM_PAIRS(6)) uut (
    .core_clk, .rst_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .crystal_input, .proc_clk_src, .gfx_clk_src, .bus_clk_src,
    .usb_clk_src, .sio24_clk_src, .mem_buffer_in, .select_bit_zero, .reference_out_a,
    .reference_out_a_oe, .reference_out_a_dbl, .select_bit_one, .bus_clock_free,
    .bus_clock_free_oe, .select_bit_two, .superio_clock_out, .superio_clock_out_oe,
    .select_bit_three, .usb_clock_out, .usb_clock_out_oe, .processor_family_strap,
    .graphics_clock_one, .graphics_clock_one_oe, .current_multiplier_strap, .bus_clock_two,
    .bus_clock_two_oe, .mode_strap, .graphics_clock_zero, .graphics_clock_zero_oe,
    .power_good_gate_n, .reference_out_b, .reference_out_b_oe, .proc_clock_stop_n,
    .proc_clock_true, .proc_clock_true_oe, .proc_clock_comp, .proc_clock_comp_oe,
    .bus_clock_one, .memory_clock_true, .memory_clock_comp, .drive_current_mult,
    .proc_rate, .gfx_rate, .bus_rate);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // single word transfer; entered and left just after a rising edge
  task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    logic rdy;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= addr;
    hwrite <= wr;
    hsize  <= 3'h2;
    do begin
      @(posedge core_clk);
      rdy = hready;
    end while (rdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do begin
      @(posedge core_clk);
      rdy   = hready;
      rdata = hrdata;
    end while (rdy !== 1'b1);
  endtask : bus_xfer

  task automatic power_up(input logic [6:0] st);
    strap <= {1'b1, st};
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (SETTLE + 3) @(posedge core_clk);
  endtask : power_up

  // each output in out_vec must show its source, now or one cycle late; reference_out_b is skipped when the family strap is high
  task automatic follow(output int bad);
    logic [12:0] prev;
    bad = 0;
    @(negedge core_clk);
    prev = src_vec;
    repeat (40) begin
      @(negedge core_clk);
      for (int i = 0; i < 13; i++) begin
        if (out_vec[i] !== src_vec[i] && out_vec[i] !== prev[i] && (i < 12 || !fam)) bad++;
      end
      prev = src_vec;
    end
    @(posedge core_clk);
  endtask : follow

  task automatic count_high(output int highs);
    highs = 0;
    repeat (8) begin
      @(negedge core_clk);
      if (proc_lvl[1] === 1'b1) highs++;
    end
    @(posedge core_clk);
  endtask : count_high

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) src_cnt <= src_cnt + 6'h01;

  // the sweep needs about 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [3:0]  code;
    int          bad;
    int          highs;
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    {rst_n, clk_en, proc_clock_stop_n, src_cnt, strap} = {3'b011, 6'h00, 8'hFF};
    {sio48, fam, mlt, mde, fail_count, compares} = '0;
    @(posedge core_clk);
    for (int c = 0; c < 16; c++) begin
      code = c[3:0];
      fam  = code[0];
      mlt  = code[1];
      mde  = code[2] ^ code[3];
      // family 1 starts on the wrong code: re-sampling while power-good is high must pick up the right one
      power_up({mde, mlt, fam, fam ? ~code : code});
      bus_xfer(1'b0, {24'h0, CSEL_OFF_CTRL}, 32'h0, d);
      check(64'(d), 64'h0);
      check(64'(reference_out_a_dbl), 64'h0);
      bus_xfer(1'b0, {24'h0, CSEL_OFF_STATUS}, 32'h0, d);
      check(64'(d[0]), 64'(!fam));
      check(64'(usb_clock_out_oe), 64'(!fam));
      check(64'(reference_out_b_oe), 64'(!fam));
      if (fam) begin
        strap[3:0] <= code;
        repeat (3) @(posedge core_clk);
        strap[7] <= 1'b0;
        repeat (4) @(posedge core_clk);
        strap[7] <= 1'b1;
      end
      follow(bad);
      check(64'(bad), 64'h0);
      check(64'(memory_clock_true ^ memory_clock_comp), 64'h3F);
      strap[7] <= 1'b0;
      repeat (3) @(posedge core_clk);
      strap[7] <= 1'b1;
      check(64'({proc_rate, gfx_rate, bus_rate}), 64'(RATE_TBL[c]));
      bus_xfer(1'b0, {24'h0, CSEL_OFF_FREQ}, 32'h0, d);
      check(64'(d), 64'({RATE_TBL[c][47:32], RATE_TBL[c][15:0]}));
      bus_xfer(1'b0, {24'h0, CSEL_OFF_STRAP}, 32'h0, d);
      check(64'(d[7:0]), 64'({1'b1, mde, mlt, fam, code}));
      check(64'(drive_current_mult), 64'(mlt ? CSEL_MULT_HIGH : CSEL_MULT_LOW));
      check(64'(drv_oe), 64'({!fam, 7'h7F}));
      check(64'(fam ? {proc_clock_true_oe, proc_clock_comp_oe}
                    : {proc_clock_true, proc_clock_comp}), fam ? 64'h3 : 64'h0);
      proc_clock_stop_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      count_high(highs);
      check(64'(highs == 0), 64'(!mde));
      bus_xfer(1'b0, {24'h0, CSEL_OFF_STATUS}, 32'h0, d);
      check(64'({d[2], d[1] & fam, d[0]}), 64'({mde, fam, 1'b1}));
      proc_clock_stop_n <= 1'b1;
      repeat (12) @(posedge core_clk);
      count_high(highs);
      check(64'(highs != 0), 64'h1);
    end
    // an unmapped write lands between the control write and its read-back
    bus_xfer(1'b1, {24'h0, CSEL_OFF_CTRL}, 32'hFFFF_FFFF, d);
    bus_xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, d);
    bus_xfer(1'b0, {24'h0, CSEL_OFF_CTRL}, 32'h0, d);
    check(64'(d), 64'h3);
    check(64'(reference_out_a_dbl), 64'h1);
    bus_xfer(1'b0, 32'h0000_0010, 32'h0, d);
    check(64'(d), 64'h0);
    sio48 = 1'b1;
    follow(bad);
    check(64'(bad), 64'h0);
    bus_xfer(1'b1, {24'h0, CSEL_OFF_CTRL}, 32'h0000_0001, d);
    bus_xfer(1'b0, {24'h0, CSEL_OFF_CTRL}, 32'h0, d);
    check(64'(d), 64'h1);
    check(64'(hresp), 64'h0);
    stop_test();
  end
endmodule : tb_clock_strap_select
